// *** core/global_config_diag_select.sv ***
`timescale 1ns/10ps
module global_config_diag_select (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wr_valid_i,
  input  wire logic [7:0]  wr_addr_i,
  input  wire logic [16:0] wr_data_i,
  input  wire logic [6:0]  rd_addr_i,
  output logic      [16:0] rd_data_o,
  input  wire logic        step_dir_mode_select_i,
  input  wire logic        overtemp_flag_i,
  input  wire logic        short_to_ground_flag_i,
  input  wire logic        pump_undervoltage_flag_i,
  input  wire logic        overtemp_warning_i,
  input  wire logic        interrupt_i,
  input  wire logic        step_i,
  input  wire logic        stall_i,
  input  wire logic        position_compare_i,
  input  wire logic        direction_i,
  input  wire logic [9:0]  table_position_i,
  input  wire logic        chopper_on_second_half_i,
  input  wire logic        skip_increment_i,
  output logic             use_analog_reference_o,
  output logic             use_internal_sense_o,
  output logic             vpwm_chopper_enable_o,
  output logic             encoder_commutation_o,
  output logic             motor_direction_o,
  output logic             fault_pin_a_o,
  output logic             fault_pin_b_o
);

  logic [16:0] global_config_flags_q;
  logic        skip_toggle_q;
  logic        pin_a_d;
  logic        pin_b_d;
  logic        sd;
  logic [7:0]  write_addr;
  logic        write_hit;
  logic        driver_error;
  logic        index_hit;

  assign sd = step_dir_mode_select_i;

  // Write address carries the write flag on top of the register address
  assign write_addr = config_flags_pkg::WRITE_ADDR_FLAG | {1'b0, config_flags_pkg::ADDR_GLOBAL_CONFIG};
  assign write_hit  = wr_valid_i && (wr_addr_i == write_addr);

  // Any of the three driver errors
  assign driver_error = overtemp_flag_i || short_to_ground_flag_i || pump_undervoltage_flag_i;
  assign index_hit    = (table_position_i == 10'h000);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      global_config_flags_q <= config_flags_pkg::RESET_VALUE;
    else if (write_hit)
      global_config_flags_q <= wr_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_data_o <= 17'h00000;
    else if (rd_addr_i == config_flags_pkg::ADDR_GLOBAL_CONFIG)
      rd_data_o <= global_config_flags_q;
    else
      rd_data_o <= 17'h00000;
  end

  // Configuration copies towards the analog, chopper and encoder blocks; motor direction is direction_i XOR bit 4
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      use_analog_reference_o <= 1'b0;
    else
      use_analog_reference_o <= global_config_flags_q[config_flags_pkg::BIT_ANALOG_SCALE];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      use_internal_sense_o <= 1'b0;
    else
      use_internal_sense_o <= global_config_flags_q[config_flags_pkg::BIT_INT_RSENSE];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      vpwm_chopper_enable_o <= 1'b0;
    else
      vpwm_chopper_enable_o <= global_config_flags_q[config_flags_pkg::BIT_VPWM_EN];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      encoder_commutation_o <= 1'b0;
    else
      encoder_commutation_o <= global_config_flags_q[config_flags_pkg::BIT_ENC_COMM];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      motor_direction_o <= 1'b0;
    else
      motor_direction_o <= direction_i ^ global_config_flags_q[config_flags_pkg::BIT_DIR_INVERT];
  end

  // Skip toggle, only counts in step/dir mode with option set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      skip_toggle_q <= 1'b0;
    else if (sd && global_config_flags_q[config_flags_pkg::BIT_B_SKIP] && skip_increment_i)
      skip_toggle_q <= ~skip_toggle_q;
  end

  // Pin A source: fault events in step/dir mode, motion signals otherwise
  always_comb
  begin
    pin_a_d = 1'b0;
    if (sd)
    begin
      // Only step/dir options count here
      if (global_config_flags_q[config_flags_pkg::BIT_A_ERROR] && driver_error)
        pin_a_d = 1'b1;
      if (global_config_flags_q[config_flags_pkg::BIT_A_OTPW] && overtemp_warning_i)
        pin_a_d = 1'b1;
    end
    else
    begin
      // Motion mode ignores bits 5 and 6
      if (global_config_flags_q[config_flags_pkg::BIT_A_STEP])
        pin_a_d = step_i;
      else
        pin_a_d = interrupt_i;
    end
  end

  // Pin B source; bit 8 means stall in step/dir mode, direction otherwise
  always_comb
  begin
    pin_b_d = 1'b0;
    if (sd)
    begin
      if (global_config_flags_q[config_flags_pkg::BIT_B_STALL] && stall_i)
        pin_b_d = 1'b1;
      if (global_config_flags_q[config_flags_pkg::BIT_B_INDEX] && index_hit)
        pin_b_d = 1'b1;
      if (global_config_flags_q[config_flags_pkg::BIT_B_ONSTATE] && chopper_on_second_half_i)
        pin_b_d = 1'b1;
      if (global_config_flags_q[config_flags_pkg::BIT_B_SKIP])
        pin_b_d = pin_b_d | skip_toggle_q;
    end
    else
    begin
      // Motion mode ignores bits 9 to 11
      if (global_config_flags_q[config_flags_pkg::BIT_B_STALL])
        pin_b_d = direction_i;
      else
        pin_b_d = position_compare_i;
    end
  end

  // Logical high means asserted; pin A shows asserted while reset lasts
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fault_pin_a_o <= 1'b1;
    else
      fault_pin_a_o <= pin_a_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fault_pin_b_o <= 1'b0;
    else
      fault_pin_b_o <= pin_b_d;
  end

  // Reset behaviour
  a_reset_clears: assert property (@(posedge clk_i)
    rst_i |=> global_config_flags_q == 17'h00000)
    else $error("config not cleared by reset");
  a_pin_a_reset: assert property (@(posedge clk_i)
    rst_i |=> fault_pin_a_o)
    else $error("pin a not asserted in reset");
  a_pin_b_reset: assert property (@(posedge clk_i)
    rst_i |=> !fault_pin_b_o)
    else $error("pin b not cleared by reset");
  a_cfg_reset: assert property (@(posedge clk_i)
    rst_i |=> !(use_analog_reference_o || use_internal_sense_o || vpwm_chopper_enable_o ||
                encoder_commutation_o || motor_direction_o))
    else $error("config outputs not cleared by reset");
  a_rd_reset: assert property (@(posedge clk_i)
    rst_i |=> rd_data_o == 17'h00000)
    else $error("read data not cleared by reset");
  a_skip_reset: assert property (@(posedge clk_i)
    rst_i |=> !skip_toggle_q)
    else $error("skip toggle not cleared by reset");

  // Register writes and reads
  a_write_stores: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_valid_i && wr_addr_i == 8'h80) |=> global_config_flags_q == $past(wr_data_i))
    else $error("write not stored");
  a_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_valid_i && wr_addr_i == 8'h80) |=> global_config_flags_q == $past(global_config_flags_q))
    else $error("register changed without write");
  a_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_addr_i == 7'h00) |=> rd_data_o == $past(global_config_flags_q))
    else $error("read data wrong");
  a_read_other: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_addr_i != 7'h00) |=> rd_data_o == 17'h00000)
    else $error("unmapped read not zero");

  // Configuration copies
  a_analog_ref: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> use_analog_reference_o == $past(global_config_flags_q[0]))
    else $error("analog reference select wrong");
  a_int_sense: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> use_internal_sense_o == $past(global_config_flags_q[1]))
    else $error("internal sense select wrong");
  a_pwm_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> vpwm_chopper_enable_o == $past(global_config_flags_q[2]))
    else $error("pwm enable not following");
  a_enc_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> encoder_commutation_o == $past(global_config_flags_q[3]))
    else $error("encoder commutation not following");
  a_dir_invert: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> motor_direction_o == ($past(direction_i) ^ $past(global_config_flags_q[4])))
    else $error("direction invert wrong");

  // Pin A
  a_pin_a_error: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[5] && overtemp_flag_i) |=> fault_pin_a_o)
    else $error("pin a missed overtemperature");
  a_pin_a_short: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[5] && short_to_ground_flag_i) |=> fault_pin_a_o)
    else $error("pin a missed short to ground");
  a_pin_a_pump: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[5] && pump_undervoltage_flag_i) |=> fault_pin_a_o)
    else $error("pin a missed pump undervoltage");
  a_pin_a_otpw: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[6] && overtemp_warning_i) |=> fault_pin_a_o)
    else $error("pin a missed warning");
  a_pin_a_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && !global_config_flags_q[5] && !global_config_flags_q[6]) |=> !fault_pin_a_o)
    else $error("pin a active without option");
  a_ignore_inactive: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[11:5] == 7'h04) |=> !fault_pin_a_o)
    else $error("inactive option drove pin a");
  a_pin_a_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (!sd && global_config_flags_q[7]) |=> fault_pin_a_o == $past(step_i))
    else $error("pin a step path wrong");
  a_pin_a_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (!sd && !global_config_flags_q[7]) |=> fault_pin_a_o == $past(interrupt_i))
    else $error("pin a interrupt path wrong");

  // Pin B
  a_pin_b_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[8] && stall_i) |=> fault_pin_b_o)
    else $error("pin b missed stall");
  a_pin_b_index: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[9] && table_position_i == 10'h000) |=> fault_pin_b_o)
    else $error("pin b missed index");
  a_pin_b_onstate: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[10] && chopper_on_second_half_i) |=> fault_pin_b_o)
    else $error("pin b missed chopper on state");
  a_pin_b_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[11:8] == 4'h0) |=> !fault_pin_b_o)
    else $error("pin b active without option");
  a_pin_b_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    !sd |=> fault_pin_b_o ==
      ($past(global_config_flags_q[8]) ? $past(direction_i) : $past(position_compare_i)))
    else $error("pin b motion path wrong");
  a_skip_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[11] && skip_increment_i) |=> skip_toggle_q != $past(skip_toggle_q))
    else $error("skip toggle missing");
  a_skip_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(sd && global_config_flags_q[11] && skip_increment_i) |=> skip_toggle_q == $past(skip_toggle_q))
    else $error("skip toggle moved without increment");
  a_skip_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd && global_config_flags_q[11:8] == 4'h8) |=> fault_pin_b_o == $past(skip_toggle_q))
    else $error("pin b not showing skip toggle");

  c_write: cover property (@(posedge clk_i) wr_valid_i && wr_addr_i == 8'h80);
  c_err_pin: cover property (@(posedge clk_i) sd && fault_pin_a_o);
  c_skip: cover property (@(posedge clk_i) sd && global_config_flags_q[11] && skip_increment_i);
  c_motion: cover property (@(posedge clk_i) !sd && global_config_flags_q[8] && fault_pin_b_o);
  c_index: cover property (@(posedge clk_i) sd && global_config_flags_q[9] && fault_pin_b_o);

endmodule

// *** pkg/global_config_flags_pkg.sv ***
package config_flags_pkg;
  localparam logic [6:0]  ADDR_GLOBAL_CONFIG = 7'h00;
  localparam logic [7:0]  WRITE_ADDR_FLAG    = 8'h80;
  localparam int          REG_WIDTH          = 17;
  localparam logic [16:0] RESET_VALUE        = 17'h00000;
  localparam int          BIT_ANALOG_SCALE   = 0;
  localparam int          BIT_INT_RSENSE     = 1;
  localparam int          BIT_VPWM_EN        = 2;
  localparam int          BIT_ENC_COMM       = 3;
  localparam int          BIT_DIR_INVERT     = 4;
  localparam int          BIT_A_ERROR        = 5;
  localparam int          BIT_A_OTPW         = 6;
  localparam int          BIT_A_STEP         = 7;
  localparam int          BIT_B_STALL        = 8;
  localparam int          BIT_B_INDEX        = 9;
  localparam int          BIT_B_ONSTATE      = 10;
  localparam int          BIT_B_SKIP         = 11;
endpackage

// *** tb/global_config_diag_select_bench.sv ***
`timescale 1ns/10ps
module global_config_diag_select_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wr_valid;
  logic [7:0]  wr_addr;
  logic [16:0] wr_data;
  logic [6:0]  rd_addr_i = 7'h00;
  logic [16:0] rd_data_o;
  logic        sd_i = 1'b1;
  logic [5:0]  err_i = 6'h07;
  logic [3:0]  sig_i = 4'h0;
  logic [9:0]  pos_i = 10'h001;
  logic        skip_i = 1'b0;
  logic [6:0]  out_o;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // Inputs: err_i = chopper, stall, warning, undervolt, short, overtemp; sig_i = dir, poscomp, step, irq
  global_config_diag_select DUT (.clk_i(clk_i), .rst_i(rst_i), .wr_valid_i(wr_valid), .wr_addr_i(wr_addr),
    .wr_data_i(wr_data), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .step_dir_mode_select_i(sd_i),
    .overtemp_flag_i(err_i[0]), .short_to_ground_flag_i(err_i[1]), .pump_undervoltage_flag_i(err_i[2]),
    .overtemp_warning_i(err_i[3]), .stall_i(err_i[4]), .chopper_on_second_half_i(err_i[5]),
    .interrupt_i(sig_i[0]), .step_i(sig_i[1]), .position_compare_i(sig_i[2]), .direction_i(sig_i[3]),
    .table_position_i(pos_i), .skip_increment_i(skip_i), .use_analog_reference_o(out_o[0]),
    .use_internal_sense_o(out_o[1]), .vpwm_chopper_enable_o(out_o[2]), .encoder_commutation_o(out_o[3]),
    .motor_direction_o(out_o[4]), .fault_pin_a_o(out_o[5]), .fault_pin_b_o(out_o[6]));
  host_model HOST (.clk_i(clk_i), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic case_ab(input logic sd, input logic [16:0] d, input logic [5:0] e, input logic [3:0] s,
                         input logic [9:0] p, input logic ea, input logic eb);
    @(posedge clk_i);
    sd_i  <= sd;
    err_i <= e;
    sig_i <= s;
    pos_i <= p;
    HOST.write_reg(1'b1, config_flags_pkg::ADDR_GLOBAL_CONFIG, d);
    settle();
    chk("fault_pin_a_o", 17'(ea), 17'(out_o[5]));
    chk("fault_pin_b_o", 17'(eb), 17'(out_o[6]));
  endtask
  task automatic test_reset;
    repeat (16) @(posedge clk_i);
    #1;
    chk("outputs in reset", 17'h00020, 17'(out_o));
    rst_i <= 1'b0;
    settle();
    chk("register after reset", 17'h00000, rd_data_o);
    $display("done test_reset");
  endtask
  task automatic test_config;
    // Motor idle throughout, so raising bit 2 is allowed
    case_ab(1'b0, 17'h1001f, 6'h00, 4'h0, 10'h001, 1'b0, 1'b0);
    chk("readback", 17'h10017, rd_data_o);
    chk("config outputs", 17'h00017, 17'(out_o[4:0]));
    case_ab(1'b0, 17'h00000, 6'h00, 4'h8, 10'h001, 1'b0, 1'b0);
    chk("config outputs", 17'h00010, 17'(out_o[4:0]));
    $display("done test_config");
  endtask
  task automatic test_unmapped;
    case_ab(1'b0, 17'h00013, 6'h00, 4'h0, 10'h001, 1'b0, 1'b0);
    HOST.write_reg(1'b1, 7'h01, 17'h1ffff);
    HOST.write_reg(1'b0, config_flags_pkg::ADDR_GLOBAL_CONFIG, 17'h1ffff);
    settle();
    chk("readback", 17'h00013, rd_data_o);
    rd_addr_i <= 7'h01;
    settle();
    chk("unmapped read", 17'h00000, rd_data_o);
    rd_addr_i <= 7'h00;
    $display("done test_unmapped");
  endtask
  task automatic test_pin_a;
    for (int i = 0; i < 3; i++)
      case_ab(1'b1, 17'h00020, 6'h01 << i, 4'h0, 10'h001, 1'b1, 1'b0);
    case_ab(1'b1, 17'h00020, 6'h08, 4'h0, 10'h001, 1'b0, 1'b0);
    case_ab(1'b1, 17'h00040, 6'h08, 4'h0, 10'h001, 1'b1, 1'b0);
    case_ab(1'b1, 17'h00040, 6'h01, 4'h0, 10'h001, 1'b0, 1'b0);
    case_ab(1'b1, 17'h00080, 6'h00, 4'h2, 10'h001, 1'b0, 1'b0);
    case_ab(1'b0, 17'h00060, 6'h0f, 4'h2, 10'h001, 1'b0, 1'b0);
    case_ab(1'b0, 17'h00000, 6'h00, 4'h1, 10'h001, 1'b1, 1'b0);
    case_ab(1'b0, 17'h00080, 6'h00, 4'h2, 10'h001, 1'b1, 1'b0);
    case_ab(1'b0, 17'h00080, 6'h00, 4'h1, 10'h001, 1'b0, 1'b0);
    $display("done test_pin_a");
  endtask
  task automatic test_pin_b;
    case_ab(1'b1, 17'h00100, 6'h10, 4'h0, 10'h001, 1'b0, 1'b1);
    case_ab(1'b1, 17'h00100, 6'h20, 4'h0, 10'h000, 1'b0, 1'b0);
    case_ab(1'b1, 17'h00200, 6'h00, 4'h0, 10'h000, 1'b0, 1'b1);
    case_ab(1'b1, 17'h00200, 6'h00, 4'h0, 10'h200, 1'b0, 1'b0);
    case_ab(1'b1, 17'h00400, 6'h20, 4'h0, 10'h001, 1'b0, 1'b1);
    case_ab(1'b1, 17'h00400, 6'h10, 4'h0, 10'h000, 1'b0, 1'b0);
    case_ab(1'b0, 17'h00000, 6'h00, 4'h4, 10'h001, 1'b0, 1'b1);
    case_ab(1'b0, 17'h00000, 6'h00, 4'h8, 10'h001, 1'b0, 1'b0);
    case_ab(1'b0, 17'h00100, 6'h00, 4'h8, 10'h001, 1'b0, 1'b1);
    case_ab(1'b0, 17'h00100, 6'h00, 4'h4, 10'h001, 1'b0, 1'b0);
    case_ab(1'b0, 17'h00600, 6'h30, 4'h0, 10'h000, 1'b0, 1'b0);
    $display("done test_pin_b");
  endtask
  task automatic test_skip;
    logic exp;
    exp = 1'b0;
    case_ab(1'b1, 17'h00800, 6'h00, 4'h0, 10'h001, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      skip_i <= 1'b1;
      @(posedge clk_i);
      skip_i <= 1'b0;
      exp = ~exp;
      settle();
      chk("fault_pin_b_o", 17'(exp), 17'(out_o[6]));
    end
    $display("done test_skip");
  endtask
  initial
  begin
    test_reset();
    test_config();
    test_unmapped();
    test_pin_a();
    test_pin_b();
    test_skip();
    complete_run();
  end
endmodule

// *** tb/host_model.sv ***
`timescale 1ns/10ps
module host_model (
  input  wire logic   clk_i,
  output logic        wr_valid_o,
  output logic [7:0]  wr_addr_o,
  output logic [16:0] wr_data_o
);
  initial
  begin
    wr_valid_o = 1'b0;
    wr_addr_o  = 8'h00;
    wr_data_o  = 17'h00000;
  end
  task automatic write_reg(input logic flag, input logic [6:0] addr, input logic [16:0] data);
    logic [16:0] d;
    d = data & ~17'h00008;
    if (d[11])
      d[10:8] = 3'h0;
    @(posedge clk_i);
    wr_valid_o <= 1'b1;
    wr_addr_o  <= {flag, addr};
    wr_data_o  <= d;
    @(posedge clk_i);
    wr_valid_o <= 1'b0;
    wr_addr_o  <= ~{flag, addr};
    wr_data_o  <= ~d;
  endtask
endmodule
